// File: design/shift_reg_defines.vh
// Purpose: constants for the four-bit universal shift register
// Assumes: mode code is {mode_select_high, mode_select_low}
// Notes: included by the design file only
// Operation
// [R1] with both mode selects high, a rising edge loads all four parallel inputs into the register. The code loads only with i_ce high and the buffer not full.
// [R2] during a parallel load the two serial inputs are ignored.
// [R3] with only the low mode select high, the register shifts toward the last bit, right serial in entering the first bit. Code needs i_ce and buffer room.
// [R4] with only the high mode select high, the register shifts toward the first bit, left serial in entering the last bit. Code needs i_ce and buffer room.
// [R5] with both mode selects low, the register holds its value.
// [R6] the driving logic should change mode selects only away from an active clock edge.
// [R7] a low clear forces all bits low at once, ahead of every mode.
// [R8] after clear releases, the register stays zero until the first edge with a non-hold mode.
`ifndef SHIFT_REG_DEFINES_VH
`define SHIFT_REG_DEFINES_VH
`define SR_WIDTH 4
`define SR_MODE_HOLD 2'h0
`define SR_MODE_RIGHT 2'h1
`define SR_MODE_LEFT 2'h2
`define SR_MODE_LOAD 2'h3
`define SR_RESET_VAL 4'h0
`define SR_BIT_FIRST 0
`define SR_BIT_SECOND 1
`define SR_BIT_THIRD 2
`define SR_BUF_DEPTH 2
`define SR_CNT_EMPTY 2'h0
`define SR_CNT_ONE 2'h1
`define SR_CNT_FULL 2'h2
`define SR_SEL_FIRST 2'h1
`define SR_SEL_SECOND 2'h2
`endif

// File: design/universal_shift_reg.v
// Purpose: four-bit universal shift register with load, both shifts and hold
// Assumes: mode, data and serial inputs come from logic on i_clk_sys; clear acts at once
// Notes: a two-entry buffer hands each new register word to a valid/ready stream
`timescale 1ns/100ps
`include "shift_reg_defines.vh"

module universal_shift_reg #(
    parameter WIDTH = `SR_WIDTH
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_ce,
    input wire i_clear_n,

    // mode and data
    input wire i_mode_select_low,
    input wire i_mode_select_high,
    input wire i_serial_right,
    input wire i_serial_left,
    input wire [WIDTH-1:0] i_par_data,

    // register bits
    output wire o_out_bit_first,
    output wire o_out_bit_second,
    output wire o_out_bit_third,
    output wire o_out_bit_last,
    output wire [WIDTH-1:0] o_reg,

    // word stream of updates
    output wire o_word_valid,
    output wire [WIDTH-1:0] o_word,
    input wire i_word_ready,
    output wire o_busy
);

    // mode decode and register
    wire [1:0] mode;
    wire mode_hold;
    wire active;
    wire room;
    wire step;
    wire clear_active;

    reg [WIDTH-1:0] reg_q;
    wire [WIDTH-1:0] reg_d;

    // two-entry buffer
    wire [WIDTH-1:0] entry_word [0:`SR_BUF_DEPTH-1];
    wire [1:0] wr_sel;

    reg wr_q;
    reg wr_d;
    reg rd_q;
    reg rd_d;
    reg [1:0] cnt_q;
    reg [1:0] cnt_d;
    wire buf_full;
    wire buf_empty;
    wire take;
    wire push;
    wire pop;

    assign mode = {i_mode_select_high, i_mode_select_low};
    assign mode_hold = (mode == `SR_MODE_HOLD);
    assign clear_active = !i_clear_n;

    // a full buffer stalls the register: throughput traded for never losing a word
    assign active = i_ce && !mode_hold; // [R5]
    assign room = !buf_full;
    assign step = active && room;

    // bit 0 is the first output, bit WIDTH-1 the last
    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
            wire from_lower;
            wire from_upper;
            reg next_bit;

            if (b == 0) begin : g_low_end
                assign from_lower = i_serial_right; // [R3]
            end else begin : g_low_mid
                assign from_lower = reg_q[b-1]; // [R3]
            end

            if (b == WIDTH - 1) begin : g_high_end
                assign from_upper = i_serial_left; // [R4]
            end else begin : g_high_mid
                assign from_upper = reg_q[b+1]; // [R4]
            end

            // serial inputs feed only the shift paths, so a load never sees them
            always @* begin
                case (mode)
                    `SR_MODE_LOAD: begin
                        next_bit = i_par_data[b]; // [R1] [R2]
                    end
                    `SR_MODE_RIGHT: begin
                        next_bit = from_lower; // [R3]
                    end
                    `SR_MODE_LEFT: begin
                        next_bit = from_upper; // [R4]
                    end
                    default: begin
                        next_bit = reg_q[b]; // [R5]
                    end
                endcase
            end

            assign reg_d[b] = next_bit;
        end
    endgenerate

    // clear is asynchronous and outranks every mode
    always @(posedge i_clk_sys or posedge i_rst or negedge i_clear_n) begin
        if (i_rst) begin
            reg_q <= `SR_RESET_VAL;
        end else if (!i_clear_n) begin
            reg_q <= `SR_RESET_VAL; // [R7]
        end else if (step) begin
            reg_q <= reg_d; // [R8]
        end
    end

    assign o_reg = reg_q;
    assign o_out_bit_first = reg_q[`SR_BIT_FIRST];
    assign o_out_bit_second = reg_q[`SR_BIT_SECOND];
    assign o_out_bit_third = reg_q[`SR_BIT_THIRD];
    assign o_out_bit_last = reg_q[WIDTH-1];

    // a word enters only with a register step, so none enters while clear is low
    assign push = step && !clear_active;
    assign take = i_word_ready && !buf_empty;
    assign pop = i_ce && take;
    assign buf_full = (cnt_q == `SR_CNT_FULL);
    assign buf_empty = (cnt_q == `SR_CNT_EMPTY);
    assign o_word_valid = !buf_empty;
    assign o_word = entry_word[rd_q];
    assign o_busy = buf_full;
    assign wr_sel = wr_q ? `SR_SEL_SECOND : `SR_SEL_FIRST;

    always @* begin
        case ({push, pop})
            2'h2: begin
                cnt_d = cnt_q + `SR_CNT_ONE;
            end
            2'h1: begin
                cnt_d = cnt_q - `SR_CNT_ONE;
            end
            2'h3: begin
                cnt_d = cnt_q;
            end
            default: begin
                cnt_d = cnt_q;
            end
        endcase
    end

    always @* begin
        if (push) begin
            wr_d = ~wr_q;
        end else begin
            wr_d = wr_q;
        end
    end

    always @* begin
        if (pop) begin
            rd_d = ~rd_q;
        end else begin
            rd_d = rd_q;
        end
    end

    // entries are flip-flops; the write index picks one, the read index shows one
    genvar e;
    generate
        for (e = 0; e < `SR_BUF_DEPTH; e = e + 1) begin : g_entry
            reg [WIDTH-1:0] word_q;
            wire wr_hit;

            assign wr_hit = push && wr_sel[e];

            always @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    word_q <= `SR_RESET_VAL;
                end else if (wr_hit) begin
                    word_q <= reg_d;
                end
            end

            assign entry_word[e] = word_q;
        end
    endgenerate

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
        end
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
        end
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= `SR_CNT_EMPTY;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// File: tb/usr_chk.sv
// Purpose: port checks; Assumes: one clock; Notes: bound below
`timescale 1ns/100ps
module usr_chk (input wire i_clk_sys, i_rst, i_ce, i_clear_n, i_mode_select_low,
    input wire i_mode_select_high, i_serial_right, i_serial_left, o_busy,
    input wire [3:0] i_par_data, input wire [3:0] o_reg);
wire c = i_clear_n, h = i_mode_select_high, l = i_mode_select_low;
wire go = i_ce && c && !o_busy;
default clocking @(posedge i_clk_sys); endclocking
default disable iff (i_rst);
a_hold_idle: assert property (!h && !l && c ##1 c |-> $stable(o_reg)) else $error("hold");
a_ce_freeze: assert property (!i_ce && c ##1 c |-> $stable(o_reg)) else $error("freeze");
a_clear_zero: assert property (!c |-> o_reg == 4'h0) else $error("clear");
a_clear_stay: assert property (!c ##1 c && !h && !l |=> o_reg == 4'h0) else $error("stay");
a_load_word: assert property (go && h && l ##1 c |-> o_reg == $past(i_par_data))
    else $error("load");
a_shift_right: assert property (go && !h && l ##1 c
    |-> o_reg == {$past(o_reg[2:0]), $past(i_serial_right)}) else $error("right");
a_shift_left: assert property (go && h && !l ##1 c
    |-> o_reg == {$past(i_serial_left), $past(o_reg[3:1])}) else $error("left");
endmodule
bind universal_shift_reg usr_chk chk(.*);

// File: tb/sink_model.sv
// Purpose: stalling consumer; Assumes: one clock; Notes: random ready so the buffer fills
`timescale 1ns/100ps
module sink_model (input wire i_clk_sys, output reg i_word_ready = 1'b0);
integer s = 32'h2d72a85e;
always @(posedge i_clk_sys) i_word_ready <= $random(s) % 2 != 0;
endmodule

// File: tb/test_universal_shift_reg.sv
// Purpose: random run of load, shifts, hold, clear and clock enable
// Assumes: inputs change by non-blocking assignment on the rising edge
// Notes: each step notes its word in a queue; the watcher checks words in order
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
$display("mismatch %s exp %h got %h", n, e, g); end end
module test_universal_shift_reg;
reg i_clk_sys = 0, i_rst = 1, i_ce = 1, i_clear_n = 1, i_serial_right = 0, i_serial_left = 0;
reg i_mode_select_low = 0, i_mode_select_high = 0;
reg [3:0] i_par_data = 4'h0, m = 4'h0, e;
wire o_word_valid, i_word_ready, o_busy, o_out_bit_first, o_out_bit_second;
wire o_out_bit_third, o_out_bit_last;
wire [3:0] o_reg, o_word;
integer seed = 32'h2d72a85e, fails = 0, samples_checked = 0;
reg [3:0] q[$];
universal_shift_reg dut(.*);
sink_model snk(.*);
always #4 i_clk_sys = ~i_clk_sys;
// clear has already acted by the edge at which the model sees it low
always @(posedge i_clk_sys) if (!i_rst) begin
    if (!i_clear_n) m = 4'h0;
    `CHK("reg", m, o_reg)
    `CHK("bits", m, {o_out_bit_last, o_out_bit_third, o_out_bit_second, o_out_bit_first})
    if (i_clear_n && i_ce && (i_mode_select_high || i_mode_select_low) && !o_busy) begin
        m = i_mode_select_low ? (i_mode_select_high ? i_par_data : {m[2:0], i_serial_right})
            : {i_serial_left, m[3:1]};
        q.push_back(m);
    end
    {i_mode_select_high, i_mode_select_low, i_serial_right, i_serial_left, i_par_data}
        <= $random(seed);
    i_clear_n <= $random(seed) % 16 != 0;
    i_ce <= $random(seed) % 8 != 0;
end
// outputs are settled at the falling edge, before the rising edge that pops
always @(negedge i_clk_sys) if (!i_rst) begin
    `CHK("busy", q.size() == 2, o_busy)
    `CHK("valid", q.size() != 0, o_word_valid)
    if (o_word_valid && i_word_ready && i_ce) begin
        e = q.pop_front();
        `CHK("word", e, o_word)
    end
end
task finish_test; begin
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
end endtask
initial begin repeat (3) @(posedge i_clk_sys); i_rst <= 0; repeat (3000) @(posedge i_clk_sys);
    finish_test; end
initial begin #30000 fails++; finish_test; end
endmodule
